// ---- src/nvm_defines.svh ----
// Offsets, field positions, reset values and timing counts for the sequencer
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH

// Register byte offsets on the APB
`define NVM_OFS_ADDR_LOW    8'h00
`define NVM_OFS_ADDR_HIGH   8'h04
`define NVM_OFS_DATA_LOW    8'h08
`define NVM_OFS_DATA_HIGH   8'h0C
`define NVM_OFS_CONTROL     8'h10
`define NVM_OFS_KEY_PORT    8'h14

// Control register bit positions
`define NVM_CTL_GO          1
`define NVM_CTL_PROG_EN     2
`define NVM_CTL_ERROR       3
`define NVM_CTL_ERASE       4
`define NVM_CTL_LATCH_ONLY  5
`define NVM_CTL_CFG_SPACE   6
`define NVM_CTL_FIXED_ONE   7

// Unlock keys and blank latch value
`define NVM_KEY_FIRST       8'h55
`define NVM_KEY_SECOND      8'hAA
`define NVM_BLANK_WORD      14'h3FFF

// Geometry
`define NVM_LATCH_COUNT     32
`define NVM_LATCH_BITS      5
`define NVM_ROW_BITS        10
`define NVM_ADDR_BITS       15
`define NVM_WORD_BITS       14

// Timing
`define NVM_CLK_PERIOD_NS   20
`define NVM_PROG_TIME_NS    2000000
`define NVM_FORCED_NOPS     2'h2

`endif

// ---- src/nvm_pkg.sv ----
// Types shared by the flash row write sequencer
package nvm_pkg;

   typedef enum logic [2:0]
   {
      SEQ_IDLE,
      SEQ_NOP,
      SEQ_WRITE,
      SEQ_ERASE,
      SEQ_WAIT,
      SEQ_DONE
   } nvm_seq_state_t;

   typedef enum logic [1:0]
   {
      KEY_IDLE,
      KEY_FIRST,
      KEY_ARMED
   } nvm_key_state_t;

endpackage : nvm_pkg

// ---- src/nvm_row_write_sequencer.sv ----
// Flash row write latch sequencer with APB registers and core stall control
`timescale 1ns/1ps
`include "nvm_defines.svh"

module nvm_row_write_sequencer
   import nvm_pkg::*;
#(
   parameter int PROG_CYCLES = `NVM_PROG_TIME_NS / `NVM_CLK_PERIOD_NS
)
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        core_interrupt,
   output logic             core_force_nop,
   output logic             core_hold,
   output logic             flash_word_we,
   output logic [14:0]      flash_word_addr,
   output logic [13:0]      flash_word_data,
   output logic             flash_row_erase,
   output logic [9:0]       flash_row_addr
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]                  nvm_address_low;
   logic [6:0]                  nvm_address_high;
   logic [7:0]                  nvm_data_low;
   logic [5:0]                  nvm_data_high;
   logic                        go;
   logic                        program_enable;
   logic                        sequence_error_flag;
   logic                        erase_select;
   logic                        latch_only_select;
   logic                        config_space_select;
   logic [13:0]                 latch_mem [`NVM_LATCH_COUNT];
   nvm_key_state_t              key_state;
   nvm_seq_state_t              seq_state;
   logic                        op_commit;
   logic [1:0]                  nop_cnt;
   logic [4:0]                  word_idx;
   logic [16:0]                 timer;
   logic [7:0]                  next_nvm_address_low;
   logic [6:0]                  next_nvm_address_high;
   logic [7:0]                  next_nvm_data_low;
   logic [5:0]                  next_nvm_data_high;
   logic                        next_go;
   logic                        next_program_enable;
   logic                        next_sequence_error_flag;
   logic                        next_erase_select;
   logic                        next_latch_only_select;
   logic                        next_config_space_select;
   logic [13:0]                 next_latch_mem [`NVM_LATCH_COUNT];
   nvm_key_state_t              next_key_state;
   nvm_seq_state_t              next_seq_state;
   logic                        next_op_commit;
   logic [1:0]                  next_nop_cnt;
   logic [4:0]                  next_word_idx;
   logic [16:0]                 next_timer;
   logic [31:0]                 next_prdata;
   logic                        next_flash_word_we;
   logic [14:0]                 next_flash_word_addr;
   logic [13:0]                 next_flash_word_data;
   logic                        next_flash_row_erase;
   logic [9:0]                  next_flash_row_addr;
   logic                        acc_phase;
   logic                        wr_access;
   logic                        go_attempt;
   logic                        go_accept;
   logic [14:0]                 full_addr;
   logic [13:0]                 data_word;
   logic [9:0]                  row_sel;
   logic [4:0]                  latch_sel;
   localparam logic [16:0] PROG_LAST = 17'(PROG_CYCLES - 1);
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= `NVM_OFS_KEY_PORT) && (a[1:0] == 2'b00);
   endfunction : is_mapped

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   // Zero wait states; unmapped offsets answer with an error
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !is_mapped(paddr);
   assign acc_phase = psel && penable;
   assign wr_access = acc_phase && pwrite;
   assign full_addr = {nvm_address_high, nvm_address_low};
   assign data_word = {nvm_data_high, nvm_data_low};
   assign row_sel   = full_addr[14:5];
   assign latch_sel = full_addr[4:0];
   assign go_attempt = wr_access && (paddr == `NVM_OFS_CONTROL)
                       && pwdata[`NVM_CTL_GO] && !go;
   // Config space writes are outside this block and are refused too
   assign go_accept  = go_attempt && (key_state == KEY_ARMED)
                       && pwdata[`NVM_CTL_PROG_EN]
                       && !pwdata[`NVM_CTL_CFG_SPACE]
                       && !core_interrupt;

   ////////////////////////////////////////////////////////////////////////////
   // Register file and unlock tracking
   always_comb
   begin
      next_nvm_address_low     = nvm_address_low;
      next_nvm_address_high    = nvm_address_high;
      next_nvm_data_low        = nvm_data_low;
      next_nvm_data_high       = nvm_data_high;
      next_program_enable      = program_enable;
      next_erase_select        = erase_select;
      next_latch_only_select   = latch_only_select;
      next_config_space_select = config_space_select;
      next_sequence_error_flag = sequence_error_flag;
      next_key_state           = key_state;
      next_prdata              = prdata;
      // Any access between key writes and go breaks the sequence
      if (acc_phase)
         next_key_state = KEY_IDLE;
      if (wr_access && !go)
      begin
         if (paddr == `NVM_OFS_ADDR_LOW)
            next_nvm_address_low = pwdata[7:0];
         else if (paddr == `NVM_OFS_ADDR_HIGH)
            next_nvm_address_high = pwdata[6:0];
         else if (paddr == `NVM_OFS_DATA_LOW)
            next_nvm_data_low = pwdata[7:0];
         else if (paddr == `NVM_OFS_DATA_HIGH)
            next_nvm_data_high = pwdata[5:0];
         else if (paddr == `NVM_OFS_CONTROL)
         begin
            next_program_enable      = pwdata[`NVM_CTL_PROG_EN];
            next_erase_select        = pwdata[`NVM_CTL_ERASE];
            next_latch_only_select   = pwdata[`NVM_CTL_LATCH_ONLY];
            next_config_space_select = pwdata[`NVM_CTL_CFG_SPACE];
            next_sequence_error_flag = pwdata[`NVM_CTL_ERROR];
         end
         else if (paddr == `NVM_OFS_KEY_PORT)
         begin
            if (pwdata[7:0] == `NVM_KEY_FIRST)
               next_key_state = KEY_FIRST;
            else if (pwdata[7:0] == `NVM_KEY_SECOND
                     && key_state == KEY_FIRST)
               next_key_state = KEY_ARMED;
         end
      end
      // Interruption mid-sequence disarms the key
      if (core_interrupt)
         next_key_state = KEY_IDLE;
      // Failed start sets the flag; set wins over a software clear
      if (go_attempt && !go_accept)
         next_sequence_error_flag = 1'b1;
      // Erase select is hardware cleared on completion
      if (seq_state == SEQ_DONE)
         next_erase_select = 1'b0;

      // Read data captured in setup, presented in the access phase
      if (psel && !penable)
      begin
         if (paddr == `NVM_OFS_ADDR_LOW)
            next_prdata = {24'h000000, nvm_address_low};
         else if (paddr == `NVM_OFS_ADDR_HIGH)
            next_prdata = {24'h000000, 1'b1, nvm_address_high};
         else if (paddr == `NVM_OFS_DATA_LOW)
            next_prdata = {24'h000000, nvm_data_low};
         else if (paddr == `NVM_OFS_DATA_HIGH)
            next_prdata = {26'h0000000, nvm_data_high};
         else if (paddr == `NVM_OFS_CONTROL)
            next_prdata = {24'h000000, 1'b1, config_space_select,
                           latch_only_select, erase_select,
                           sequence_error_flag, program_enable, go, 1'b0};
         else
            next_prdata = 32'h00000000;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         nvm_address_low     <= 8'h00;
         nvm_address_high    <= 7'h00;
         nvm_data_low        <= 8'h00;
         nvm_data_high       <= 6'h00;
         program_enable      <= 1'b0;
         erase_select        <= 1'b0;
         latch_only_select   <= 1'b0;
         config_space_select <= 1'b0;
         sequence_error_flag <= 1'b0;
         key_state           <= KEY_IDLE;
         prdata              <= 32'h00000000;
      end
      else
      begin
         nvm_address_low     <= next_nvm_address_low;
         nvm_address_high    <= next_nvm_address_high;
         nvm_data_low        <= next_nvm_data_low;
         nvm_data_high       <= next_nvm_data_high;
         program_enable      <= next_program_enable;
         erase_select        <= next_erase_select;
         latch_only_select   <= next_latch_only_select;
         config_space_select <= next_config_space_select;
         sequence_error_flag <= next_sequence_error_flag;
         key_state           <= next_key_state;
         prdata              <= next_prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latch buffer and programming sequencer
   always_comb
   begin
      next_seq_state       = seq_state;
      next_go              = go;
      next_op_commit       = op_commit;
      next_nop_cnt         = nop_cnt;
      next_word_idx        = word_idx;
      next_timer           = timer;
      next_flash_word_we   = 1'b0;
      next_flash_word_addr = flash_word_addr;
      next_flash_word_data = flash_word_data;
      next_flash_row_erase = 1'b0;
      next_flash_row_addr  = flash_row_addr;
      for (int i = 0; i < `NVM_LATCH_COUNT; i++)
         next_latch_mem[i] = latch_mem[i];

      case (seq_state)
         SEQ_IDLE:
         begin
            if (go_accept)
            begin
               next_go        = 1'b1;
               next_nop_cnt   = 2'h0;
               next_seq_state = SEQ_NOP;
               if (pwdata[`NVM_CTL_ERASE])
                  next_op_commit = 1'b1;
               else
               begin
                  next_latch_mem[latch_sel] = data_word;
                  next_op_commit = !pwdata[`NVM_CTL_LATCH_ONLY];
               end
            end
         end
         SEQ_NOP:
         begin
            next_nop_cnt = nop_cnt + 2'h1;
            if (nop_cnt == `NVM_FORCED_NOPS - 2'h1)
            begin
               next_word_idx = 5'h00;
               next_timer    = 17'h00000;
               if (!op_commit)
               begin
                  next_go        = 1'b0;
                  next_seq_state = SEQ_IDLE;
               end
               else if (erase_select)
                  next_seq_state = SEQ_ERASE;
               else
                  next_seq_state = SEQ_WRITE;
            end
         end
         SEQ_WRITE:
         begin
            // Words go out one per cycle; cells are only programmed
            next_flash_word_we   = 1'b1;
            next_flash_word_addr = {row_sel, word_idx};
            next_flash_word_data = latch_mem[word_idx];
            next_word_idx        = word_idx + 5'h01;
            if (word_idx == 5'(`NVM_LATCH_COUNT - 1))
               next_seq_state = SEQ_WAIT;
         end
         SEQ_ERASE:
         begin
            next_flash_row_erase = 1'b1;
            next_flash_row_addr  = row_sel;
            next_seq_state       = SEQ_WAIT;
         end
         SEQ_WAIT:
         begin
            // Self-timed cell programming or erase interval
            next_timer = timer + 17'h00001;
            if (timer == PROG_LAST)
               next_seq_state = SEQ_DONE;
         end
         SEQ_DONE:
         begin
            for (int i = 0; i < `NVM_LATCH_COUNT; i++)
               next_latch_mem[i] = `NVM_BLANK_WORD;
            next_go        = 1'b0;
            next_op_commit = 1'b0;
            next_seq_state = SEQ_IDLE;
         end
         default:
            next_seq_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         seq_state       <= SEQ_IDLE;
         go              <= 1'b0;
         op_commit       <= 1'b0;
         nop_cnt         <= 2'h0;
         word_idx        <= 5'h00;
         timer           <= 17'h00000;
         flash_word_we   <= 1'b0;
         flash_word_addr <= 15'h0000;
         flash_word_data <= 14'h0000;
         flash_row_erase <= 1'b0;
         flash_row_addr  <= 10'h000;
         for (int i = 0; i < `NVM_LATCH_COUNT; i++)
            latch_mem[i] <= `NVM_BLANK_WORD;
      end
      else
      begin
         seq_state       <= next_seq_state;
         go              <= next_go;
         op_commit       <= next_op_commit;
         nop_cnt         <= next_nop_cnt;
         word_idx        <= next_word_idx;
         timer           <= next_timer;
         flash_word_we   <= next_flash_word_we;
         flash_word_addr <= next_flash_word_addr;
         flash_word_data <= next_flash_word_data;
         flash_row_erase <= next_flash_row_erase;
         flash_row_addr  <= next_flash_row_addr;
         for (int i = 0; i < `NVM_LATCH_COUNT; i++)
            latch_mem[i] <= next_latch_mem[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core stall outputs
   assign core_force_nop = (seq_state == SEQ_NOP);
   // Hold covers streaming, erase and the whole self-timed wait
   assign core_hold = (seq_state == SEQ_WRITE)
                      || (seq_state == SEQ_ERASE)
                      || (seq_state == SEQ_WAIT)
                      || (seq_state == SEQ_DONE);

endmodule : nvm_row_write_sequencer

// ---- bench/nvm_seq_monitor.sv ----
// Port-level checks for the row write sequencer
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_seq_monitor
#(
   parameter int PROG_CYCLES = 8
)
(
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        core_interrupt,
   input wire logic        core_force_nop,
   input wire logic        core_hold,
   input wire logic        flash_word_we,
   input wire logic [14:0] flash_word_addr,
   input wire logic [13:0] flash_word_data,
   input wire logic        flash_row_erase,
   input wire logic [9:0]  flash_row_addr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic        go_req;
   logic [7:0]  we_run;
   logic [7:0]  next_we_run;
   logic [31:0] hold_cnt;
   logic [31:0] next_hold_cnt;
   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      go_req = psel && penable && pwrite && !core_interrupt &&
               paddr == `NVM_OFS_CONTROL && pwdata[`NVM_CTL_GO] &&
               pwdata[`NVM_CTL_PROG_EN];
      next_we_run = flash_word_we ? we_run + 8'h01 : 8'h00;
      next_hold_cnt = core_hold ? hold_cnt + 32'h1 : 32'h0;
   end
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         we_run <= 8'h00;
         hold_cnt <= 32'h0;
      end
      else
      begin
         we_run <= next_we_run;
         hold_cnt <= next_hold_cnt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_nop_pair;
      core_force_nop ##1 core_force_nop ##1 !core_force_nop;
   endsequence
   sequence s_no_stall;
      !core_hold ##1 !core_hold ##1 !core_hold ##1 !core_hold;
   endsequence
   property p_nop_pair;
      $rose(core_force_nop) |-> s_nop_pair;
   endproperty
   property p_nop_cause;
      $rose(core_force_nop) |-> $past(go_req);
   endproperty
   property p_latch_only;
      $rose(core_force_nop) && $past(go_req && pwdata[`NVM_CTL_LATCH_ONLY]
         && !pwdata[`NVM_CTL_ERASE]) |-> s_no_stall;
   endproperty
   property p_commit_hold;
      $rose(core_force_nop) && $past(!pwdata[`NVM_CTL_LATCH_ONLY])
         |-> ##2 core_hold;
   endproperty
   property p_erase_go;
      $rose(core_force_nop) && $past(pwdata[`NVM_CTL_ERASE])
         |-> ##3 flash_row_erase && !flash_word_we;
   endproperty
   property p_burst;
      $fell(flash_word_we) |-> we_run == 8'h20;
   endproperty
   property p_first;
      $rose(flash_word_we) |-> flash_word_addr[4:0] == 5'h00;
   endproperty
   property p_step;
      flash_word_we && $past(flash_word_we) |->
         flash_word_addr[14:5] == $past(flash_word_addr[14:5]) &&
         flash_word_addr[4:0] == $past(flash_word_addr[4:0]) + 5'h01;
   endproperty
   property p_strobe_held;
      flash_word_we || flash_row_erase |-> core_hold && !core_force_nop;
   endproperty
   property p_hold_max;
      core_hold |-> hold_cnt < PROG_CYCLES + 64;
   endproperty
   a_nop_pair: assert property (p_nop_pair)
      else $error("forced nop not two cycles");
   a_nop_cause: assert property (p_nop_cause)
      else $error("nop without valid go");
   a_latch_only: assert property (p_latch_only)
      else $error("latch load stalled core");
   a_commit_hold: assert property (p_commit_hold)
      else $error("commit did not stall");
   a_erase_go: assert property (p_erase_go)
      else $error("erase pulse missing");
   a_burst: assert property (p_burst)
      else $error("burst length not 32");
   a_first: assert property (p_first)
      else $error("burst not row aligned");
   a_step: assert property (p_step)
      else $error("word address step wrong");
   a_strobe_held: assert property (p_strobe_held)
      else $error("strobe outside hold");
   a_hold_max: assert property (p_hold_max)
      else $error("hold too long");
endmodule : nvm_seq_monitor

// ---- bench/nvm_flash_model.sv ----
// Behavioural flash array recording programmed words and erases
`timescale 1ns/1ps
module nvm_flash_model
(
   input wire logic        core_clk,
   input wire logic        flash_word_we,
   input wire logic [14:0] flash_word_addr,
   input wire logic [13:0] flash_word_data,
   input wire logic        flash_row_erase,
   input wire logic [9:0]  flash_row_addr
);
   logic [13:0] last [0:32767];
   int          wr_count = 0;
   int          er_count = 0;
   logic [9:0]  er_row = 10'h000;
   // Program stores the word only; never erases
   always @(posedge core_clk)
   begin
      if (flash_word_we)
      begin
         last[flash_word_addr] <= flash_word_data;
         wr_count <= wr_count + 1;
      end
      if (flash_row_erase)
      begin
         er_count <= er_count + 1;
         er_row <= flash_row_addr;
         // Whole row back to blank; no partial erase
         for (int i = 0; i < 32; i++)
            last[{flash_row_addr, 5'(i)}] <= 14'h3FFF;
      end
   end
endmodule : nvm_flash_model

// ---- bench/tb_flash_row_write_latch_sequencer.sv ----
// Self-checking bench for the row write sequencer
`timescale 1ns/1ps
`include "nvm_defines.svh"
module tb_flash_row_write_latch_sequencer;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        core_interrupt = 1'b0;
   logic        core_force_nop;
   logic        core_hold;
   logic        flash_word_we;
   logic [14:0] flash_word_addr;
   logic [13:0] flash_word_data;
   logic        flash_row_erase;
   logic [9:0]  flash_row_addr;
   logic [31:0] q;
   logic        err;
   int          n_fail = 0;
   int          cmp_count = 0;
   always #10 core_clk = ~core_clk;
   nvm_row_write_sequencer #(.PROG_CYCLES(8)) dut
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_interrupt(core_interrupt),
      .core_force_nop(core_force_nop), .core_hold(core_hold),
      .flash_word_we(flash_word_we), .flash_word_addr(flash_word_addr),
      .flash_word_data(flash_word_data),
      .flash_row_erase(flash_row_erase), .flash_row_addr(flash_row_addr)
   );
   nvm_flash_model fm
   (
      .core_clk(core_clk), .flash_word_we(flash_word_we),
      .flash_word_addr(flash_word_addr),
      .flash_word_data(flash_word_data),
      .flash_row_erase(flash_row_erase), .flash_row_addr(flash_row_addr)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic unlock(input logic [7:0] c);
      apb(1'b1, `NVM_OFS_KEY_PORT, {24'h000000, `NVM_KEY_FIRST});
      apb(1'b1, `NVM_OFS_KEY_PORT, {24'h000000, `NVM_KEY_SECOND});
      apb(1'b1, `NVM_OFS_CONTROL, {24'h000000, c});
   endtask : unlock
   // Next unlock only once go reads back clear
   task automatic wait_go;
      for (int i = 0; i < 100; i++)
      begin
         apb(1'b0, `NVM_OFS_CONTROL, 32'h0);
         if (q[`NVM_CTL_GO] === 1'b0) break;
      end
      chk({31'h0, q[`NVM_CTL_GO]}, 32'h0);
   endtask : wait_go
   task automatic ld(input logic [7:0] lo, input logic [13:0] d,
                     input logic [7:0] c);
      apb(1'b1, `NVM_OFS_ADDR_LOW, {24'h000000, lo});
      apb(1'b1, `NVM_OFS_DATA_LOW, {24'h000000, d[7:0]});
      apb(1'b1, `NVM_OFS_DATA_HIGH, {26'h0000000, d[13:8]});
      unlock(c);
      wait_go();
   endtask : ld
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      apb(1'b0, `NVM_OFS_ADDR_HIGH, 32'h0);
      chk(q, 32'h80);
      chk({31'h0, err}, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `NVM_OFS_ADDR_HIGH, 32'h2A);
      apb(1'b1, `NVM_OFS_CONTROL, 32'h24);
      ld(8'hA3, 14'h1234, 8'h26);
      // Unlock broken by an intervening read
      apb(1'b1, `NVM_OFS_ADDR_LOW, 32'hA7);
      apb(1'b1, `NVM_OFS_KEY_PORT, 32'h55);
      apb(1'b0, `NVM_OFS_DATA_LOW, 32'h0);
      apb(1'b1, `NVM_OFS_KEY_PORT, 32'hAA);
      apb(1'b1, `NVM_OFS_CONTROL, 32'h26);
      apb(1'b0, `NVM_OFS_CONTROL, 32'h0);
      chk(q, 32'hAC);
      apb(1'b1, `NVM_OFS_CONTROL, 32'h24);
      core_interrupt <= 1'b1;
      apb(1'b1, `NVM_OFS_ADDR_LOW, 32'hA8);
      unlock(8'h26);
      core_interrupt <= 1'b0;
      apb(1'b0, `NVM_OFS_CONTROL, 32'h0);
      chk(q, 32'hAC);
      apb(1'b1, `NVM_OFS_CONTROL, 32'h20);
      apb(1'b1, `NVM_OFS_ADDR_LOW, 32'hA9);
      unlock(8'h22);
      apb(1'b0, `NVM_OFS_CONTROL, 32'h0);
      chk(q, 32'hA8);
      apb(1'b1, `NVM_OFS_CONTROL, 32'h24);
      chk(fm.wr_count, 32'h0);
      ld(8'hBF, 14'h3ABC, 8'h06);
      chk(fm.wr_count, 32'd32);
      chk(fm.er_count, 32'h0);
      chk(fm.last[15'h2AA3], 32'h1234);
      chk(fm.last[15'h2AA7], 32'h3FFF);
      chk(fm.last[15'h2AA8], 32'h3FFF);
      chk(fm.last[15'h2AA9], 32'h3FFF);
      chk(fm.last[15'h2ABF], 32'h3ABC);
      apb(1'b0, `NVM_OFS_CONTROL, 32'h0);
      chk(q, 32'h84);
      // Latches must be blank after the commit; fresh row, never written
      apb(1'b1, `NVM_OFS_ADDR_HIGH, 32'h2B);
      ld(8'hA0, 14'h0F0F, 8'h06);
      chk(fm.last[15'h2BA3], 32'h3FFF);
      chk(fm.last[15'h2BBF], 32'h3FFF);
      chk(fm.last[15'h2BA0], 32'h0F0F);
      // Erase wins over latch-only
      apb(1'b1, `NVM_OFS_CONTROL, 32'h24);
      ld(8'hA4, 14'h0111, 8'h26);
      unlock(8'h36);
      wait_go();
      chk(fm.er_count, 32'h1);
      chk({22'h0, fm.er_row}, 32'h15D);
      chk(fm.last[15'h2BA0], 32'h3FFF);
      chk(fm.wr_count, 32'd64);
      apb(1'b0, `NVM_OFS_CONTROL, 32'h0);
      chk(q, 32'hA4);
      ld(8'hA1, 14'h2222, 8'h06);
      chk(fm.last[15'h2BA4], 32'h3FFF);
      chk(fm.last[15'h2BA1], 32'h2222);
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      stop_test();
   end
endmodule : tb_flash_row_write_latch_sequencer
bind nvm_row_write_sequencer nvm_seq_monitor
   #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.*);
